// [bench/debug_link_flash_programming_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_link_flash_programming_regs_tb;
	// link ops and selector values
	localparam logic [2:0] OP_DR = 3'h0;
	localparam logic [2:0] OP_DW = 3'h1;
	localparam logic [2:0] OP_AW = 3'h2;
	localparam logic [2:0] OP_AR = 3'h3;
	localparam logic [7:0] CTL   = dlf_pkg::DLF_SEL_CTRL;
	localparam logic [7:0] DAT   = dlf_pkg::DLF_SEL_DATA;
	// clock, reset and host register port
	logic       clk_in = 1'b0;
	logic       arst_n_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0;
	logic       rd_in = 1'b0;
	logic [7:0] rdata_out;
	// device system side
	logic       halted_in = 1'b1;
	logic       rd_byte_load_in = 1'b0;
	logic [7:0] rd_byte_in = 8'h00;
	logic       prog_mode_out;
	logic       prog_byte_valid_out;
	logic       prog_byte_is_cmd_out;
	logic [7:0] prog_byte_out;
	// expected results; rd_q bit 8 set where the value matters, pb_q bit 8 is the command flag
	logic [8:0] rd_q[$];
	logic [8:0] pb_q[$];
	logic [8:0] note;
	logic       rd_seen = 1'b0;
	logic [7:0] v;
	logic [7:0] cmd_tab [0:3];
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         cycles = 0;

	dlf_link_if link ();
	dlf_host u_dlf_host (.link(link), .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
	dlf_device u_dlf_device (.link(link), .clk_in(clk_in), .arst_n_in(arst_n_in),
		.halted_in(halted_in), .prog_mode_out(prog_mode_out),
		.prog_byte_valid_out(prog_byte_valid_out), .prog_byte_out(prog_byte_out),
		.prog_byte_is_cmd_out(prog_byte_is_cmd_out), .rd_byte_load_in(rd_byte_load_in),
		.rd_byte_in(rd_byte_in));
	dlf_link_assertions u_dlf_link_assertions (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.link_clk(link.link_clk), .host_d_out(link.host_d_out), .host_d_oe(link.host_d_oe),
		.dev_d_out(link.dev_d_out), .dev_d_oe(link.dev_d_oe), .data(link.data),
		.clash(link.clash));

	// 40 MHz system clock
	always #12.5 clk_in = ~clk_in;

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// read data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (rd_seen) begin
			note = rd_q.pop_front();
			if (note[8]) check({1'b1, rdata_out}, note);
		end
		rd_seen <= rd_in;
	end

	// a pulse with no note pending pops X and so shows up as a mismatch
	always @(posedge clk_in) begin
		if (prog_byte_valid_out === 1'b1) begin
			check({prog_byte_is_cmd_out, prog_byte_out}, pb_q.pop_front());
		end
	end

	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [1:0] a, input logic [8:0] n, output logic [7:0] d);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		rd_q.push_back(n);
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : reg_rd

	// one link frame: load the byte, start the op, poll done, clear it
	task automatic frame(input logic [2:0] op, input logic [7:0] tx);
		logic [7:0] st;
		st = 8'h00;
		reg_wr(dlf_pkg::DLF_HREG_TX, tx);
		reg_wr(dlf_pkg::DLF_HREG_CMD, {5'h00, op});
		// room for the three-frame unlock op; a poll that runs out is a mismatch
		for (int k = 0; k < 200 && st[dlf_pkg::DLF_STAT_DONE] !== 1'b1; k++) begin
			reg_rd(dlf_pkg::DLF_HREG_STAT, 9'h000, st);
		end
		check({8'h00, st[dlf_pkg::DLF_STAT_DONE]}, 9'h001);
		reg_wr(dlf_pkg::DLF_HREG_STAT, 8'h02);
	endtask : frame

	task automatic link_wr(input logic [7:0] sel, input logic [7:0] d);
		frame(OP_AW, sel);
		frame(OP_DW, d);
	endtask : link_wr

	task automatic link_rd(input logic [7:0] sel, input logic [2:0] op, input logic [7:0] exp);
		logic [7:0] d;
		frame(OP_AW, sel);
		frame(op, 8'h00);
		reg_rd(dlf_pkg::DLF_HREG_RX, {1'b1, exp}, d);
	endtask : link_rd

	task automatic mode_is(input logic e);
		repeat (4) @(posedge clk_in);
		check({8'h00, prog_mode_out}, {8'h00, e});
	endtask : mode_is

	// main sequence
	initial begin
		void'($urandom(32'h0b63));
		cmd_tab = '{dlf_pkg::DLF_CMD_BLK_RD, dlf_pkg::DLF_CMD_BLK_WR,
			dlf_pkg::DLF_CMD_PG_ERASE, dlf_pkg::DLF_CMD_DEV_ERASE};
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		// control and data registers come up at zero; the selector reads back as written
		link_rd(CTL, OP_DR, 8'h00);
		link_rd(DAT, OP_DR, 8'h00);
		link_rd(DAT, OP_AR, DAT);
		$display("test reset_values done");
		// second code alone, first code alone, then the proper pair
		link_wr(CTL, dlf_pkg::DLF_UNLOCK_B);
		mode_is(1'b0);
		link_wr(CTL, dlf_pkg::DLF_UNLOCK_A);
		mode_is(1'b0);
		frame(OP_DW, dlf_pkg::DLF_UNLOCK_B);
		mode_is(1'b1);
		link_rd(CTL, OP_DR, dlf_pkg::DLF_UNLOCK_B);
		$display("test unlock done");
		// every command code, then a byte with bit 4 set, which no command has
		frame(OP_AW, DAT);
		for (int i = 0; i < 5; i++) begin
			v = (i < 4) ? cmd_tab[i] : (8'($urandom()) | 8'h10);
			pb_q.push_back({i < 4, v});
			frame(OP_DW, v);
		end
		$display("test commands done");
		// flash byte needs link edges to arrive, so the selector frame comes first
		v = 8'($urandom());
		rd_byte_in <= v;
		rd_byte_load_in <= 1'b1;
		@(posedge clk_in);
		rd_byte_load_in <= 1'b0;
		link_rd(DAT, OP_DR, v);
		$display("test flash_read done");
		// while running, frames are walked but the device neither stores nor drives
		halted_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		link_rd(CTL, OP_DR, 8'hff);
		halted_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		frame(OP_AR, 8'h00);
		reg_rd(dlf_pkg::DLF_HREG_RX, {1'b1, DAT}, v);
		$display("test not_halted done");
		// programming mode stays until a system reset, which locks it again
		mode_is(1'b1);
		arst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'b1;
		mode_is(1'b0);
		link_wr(DAT, dlf_pkg::DLF_CMD_BLK_WR);
		link_rd(DAT, OP_DR, dlf_pkg::DLF_CMD_BLK_WR);
		$display("test reset_relock done");
		// host-run unlock op: selector frame, then both codes back to back
		frame(dlf_pkg::DLF_OP_UNLOCK, 8'h00);
		mode_is(1'b1);
		link_rd(CTL, OP_DR, dlf_pkg::DLF_UNLOCK_B);
		$display("test unlock_op done");
		repeat (20) @(posedge clk_in);
		// every noted byte must have been handed over
		check(9'(pb_q.size()), 9'h000);
		results();
	end
endmodule : debug_link_flash_programming_regs_tb
`default_nettype wire

// [bench/dlf_link_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dlf_link_assertions (
	// system clock and reset
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	// link wires
	input  wire logic link_clk,
	input  wire logic host_d_out,
	input  wire logic host_d_oe,
	input  wire logic dev_d_out,
	input  wire logic dev_d_oe,
	input  wire logic data,
	input  wire logic clash
);
	// link clock phases last 4 system cycles each
	chk_clk_low_len: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$fell(link_clk) |-> (!link_clk)[*4] ##1 link_clk) else $error("link low phase length");
	chk_clk_high_len: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(link_clk) |-> link_clk[*4]) else $error("link high phase too short");
	// one data line, never driven from both ends
	chk_no_clash: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!clash) else $error("both ends drive data");
	// a frame opens with a low start bit on the falling clock
	chk_start_bit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(host_d_oe) |-> $fell(link_clk) && !data) else $error("bad start bit");
	// host bits move on the fall so the device samples settled data on the rise
	chk_host_data_edge: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		host_d_oe && $past(host_d_oe) && $changed(host_d_out) |-> $fell(link_clk))
		else $error("host data moved off the falling clock");
	chk_dev_data_edge: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		dev_d_oe && $changed(dev_d_out) |-> link_clk) else $error("device data moved while low");
	// device holds the wire for exactly the eight read bits, host already off
	chk_dev_drive_len: assert property (@(posedge link_clk) disable iff (!arst_n_in)
		$rose(dev_d_oe) |-> dev_d_oe[*8] ##1 !dev_d_oe) else $error("device drive length");
	chk_dev_turnaround: assert property (@(posedge link_clk) disable iff (!arst_n_in)
		$rose(dev_d_oe) |-> !host_d_oe) else $error("host still drives at turnaround");
	// main scenarios reached
	cov_host_frame: cover property (@(posedge clk_in) $rose(host_d_oe));
	cov_dev_read: cover property (@(posedge link_clk) $rose(dev_d_oe));
	cov_dev_zero: cover property (@(posedge link_clk) dev_d_oe && !dev_d_out);
endmodule : dlf_link_assertions
`default_nettype wire

// [inc/dlf_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dlf_link_if;
	logic link_clk;
	logic host_d_out;
	logic host_d_oe;
	logic dev_d_out;
	logic dev_d_oe;
	logic data;
	logic clash;
	// shared data wire with a pull-up; host wins if both drive
	assign data  = host_d_oe ? host_d_out : (dev_d_oe ? dev_d_out : 1'b1);
	assign clash = host_d_oe & dev_d_oe;
	modport device (input link_clk, input data, output dev_d_out, output dev_d_oe);
	modport host (output link_clk, output host_d_out, output host_d_oe, input data);
endinterface : dlf_link_if
`default_nettype wire

// [inc/dlf_pkg.sv]
package dlf_pkg;
	// link register selector values
	localparam logic [7:0] DLF_SEL_CTRL     = 8'h02;
	localparam logic [7:0] DLF_SEL_DATA     = 8'hb4;
	// values after reset
	localparam logic [7:0] DLF_BYTE_RST     = 8'h00;
	localparam logic       DLF_BIT_RST      = 1'h0;
	// unlock codes, in the order they must arrive
	localparam logic [7:0] DLF_UNLOCK_A     = 8'h02;
	localparam logic [7:0] DLF_UNLOCK_B     = 8'h01;
	// flash command codes
	localparam logic [7:0] DLF_CMD_BLK_RD   = 8'h06;
	localparam logic [7:0] DLF_CMD_BLK_WR   = 8'h07;
	localparam logic [7:0] DLF_CMD_PG_ERASE = 8'h08;
	localparam logic [7:0] DLF_CMD_DEV_ERASE = 8'h03;
	// bit counts inside a frame
	localparam logic [2:0] DLF_LAST_BIT     = 3'h7;
	localparam logic [2:0] DLF_INS_LAST     = 3'h1;
	// host slots inside a frame
	localparam logic [3:0] DLF_SLOT_DATA0   = 4'h3;
	localparam logic [3:0] DLF_SLOT_RX0     = 4'h4;
	localparam logic [3:0] DLF_SLOT_WR_LAST = 4'ha;
	localparam logic [3:0] DLF_SLOT_RD_LAST = 4'hb;
	// host link clock timing, least low and high time
	localparam int         DLF_CLK_NS       = 25;
	localparam int         DLF_HALF_NS      = 100;
	localparam int         DLF_HALF_CYC     = (DLF_HALF_NS + DLF_CLK_NS - 1) / DLF_CLK_NS;
	localparam logic [2:0] DLF_PH_RISE      = 3'(DLF_HALF_CYC);
	localparam logic [2:0] DLF_PH_SAMP      = 3'(DLF_HALF_CYC - 1);
	localparam logic [2:0] DLF_PH_LAST      = 3'(2 * DLF_HALF_CYC - 1);
	// host register offsets and fields
	localparam logic [1:0] DLF_HREG_CMD     = 2'h0;
	localparam logic [1:0] DLF_HREG_TX      = 2'h1;
	localparam logic [1:0] DLF_HREG_RX      = 2'h2;
	localparam logic [1:0] DLF_HREG_STAT    = 2'h3;
	localparam int         DLF_STAT_BUSY    = 0;
	localparam int         DLF_STAT_DONE    = 1;
	localparam logic [2:0] DLF_OP_UNLOCK    = 3'h4;
	localparam logic [1:0] DLF_UNLOCK_STEPS = 2'h2;
	// link instructions
	typedef enum logic [1:0] {
		DLF_INS_DATA_RD = 2'h0,
		DLF_INS_DATA_WR = 2'h1,
		DLF_INS_ADDR_WR = 2'h2,
		DLF_INS_ADDR_RD = 2'h3
	} dlf_ins_t;
	// device frame states
	typedef enum logic [4:0] {
		DLF_FR_IDLE = 5'b00001,
		DLF_FR_INS  = 5'b00010,
		DLF_FR_WDAT = 5'b00100,
		DLF_FR_TURN = 5'b01000,
		DLF_FR_RDAT = 5'b10000
	} dlf_frame_t;
	// unlock sequence states
	typedef enum logic [2:0] {
		DLF_LK_LOCKED = 3'b001,
		DLF_LK_ARMED  = 3'b010,
		DLF_LK_OPEN   = 3'b100
	} dlf_lock_t;
endpackage : dlf_pkg

// [rtl/dlf_device.sv]
`timescale 1ns/1ps
`default_nettype none
module dlf_device (
	// link side
	dlf_link_if.device      link,
	// system clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// halt and programming state
	input  wire logic       halted_in,
	output logic            prog_mode_out,
	// bytes written by the host while unlocked
	output logic            prog_byte_valid_out,
	output logic [7:0]      prog_byte_out,
	output logic            prog_byte_is_cmd_out,
	// flash byte offered to the host for reading
	input  wire logic       rd_byte_load_in,
	input  wire logic [7:0] rd_byte_in
);
	dlf_pkg::dlf_frame_t fr_reg;
	dlf_pkg::dlf_ins_t   ins_reg;
	dlf_pkg::dlf_lock_t  lock_reg;
	logic [2:0]          cnt_reg;
	logic [7:0]          sh_reg;
	logic [7:0]          rsh_reg;
	logic                live_reg;
	logic [7:0]          sel_reg;
	logic [7:0]          ctrl_reg;
	logic [7:0]          data_reg;
	logic                wr_tgl_reg;
	logic                d_out_reg;
	logic                d_oe_reg;
	logic                halt_src_reg;
	logic                halt_lk;
	logic                rd_tgl_reg;
	logic [7:0]          rd_hold_reg;
	logic                rd_tgl_lk;
	logic                rd_seen_reg;
	logic                wr_tgl_sys;
	logic                wr_seen_reg;
	logic [1:0]          ins_now;
	logic [7:0]          byte_now;
	logic                wr_done;
	logic                ctrl_wr;
	logic                data_wr;
	logic                rd_load_lk;
	logic [7:0]          rd_val;

	// decode of the bit arriving on this edge
	assign ins_now    = {link.data, ins_reg[1]};
	assign byte_now   = {link.data, sh_reg[7:1]};
	assign wr_done    = (fr_reg == dlf_pkg::DLF_FR_WDAT) && (cnt_reg == dlf_pkg::DLF_LAST_BIT)
		&& live_reg;
	assign ctrl_wr    = wr_done && (ins_reg == dlf_pkg::DLF_INS_DATA_WR)
		&& (sel_reg == dlf_pkg::DLF_SEL_CTRL);
	assign data_wr    = wr_done && (ins_reg == dlf_pkg::DLF_INS_DATA_WR)
		&& (sel_reg == dlf_pkg::DLF_SEL_DATA);
	assign rd_load_lk = rd_tgl_lk ^ rd_seen_reg;

	// read value; unmapped selector values read as zero
	always_comb begin
		if (ins_reg == dlf_pkg::DLF_INS_ADDR_RD) begin
			rd_val = sel_reg;
		end else if (sel_reg == dlf_pkg::DLF_SEL_CTRL) begin
			rd_val = ctrl_reg;
		end else if (sel_reg == dlf_pkg::DLF_SEL_DATA) begin
			rd_val = data_reg;
		end else begin
			rd_val = dlf_pkg::DLF_BYTE_RST;
		end
	end

	// frame sequencer on the host's clock, bits sampled on rising edges
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fr_reg   <= dlf_pkg::DLF_FR_IDLE;
			ins_reg  <= dlf_pkg::DLF_INS_DATA_RD;
			cnt_reg  <= 3'h0;
			sh_reg   <= dlf_pkg::DLF_BYTE_RST;
			live_reg <= dlf_pkg::DLF_BIT_RST;
		end else begin
			case (fr_reg)
				dlf_pkg::DLF_FR_IDLE: begin
					cnt_reg <= 3'h0;
					if (!link.data) begin
						fr_reg <= dlf_pkg::DLF_FR_INS;
					end
				end
				dlf_pkg::DLF_FR_INS: begin
					ins_reg <= dlf_pkg::dlf_ins_t'(ins_now);
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == dlf_pkg::DLF_INS_LAST) begin
						cnt_reg  <= 3'h0;
						live_reg <= halt_lk;
						fr_reg   <= (^ins_now) ? dlf_pkg::DLF_FR_WDAT : dlf_pkg::DLF_FR_TURN;
					end
				end
				dlf_pkg::DLF_FR_WDAT: begin
					sh_reg  <= byte_now;
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == dlf_pkg::DLF_LAST_BIT) begin
						fr_reg <= dlf_pkg::DLF_FR_IDLE;
					end
				end
				dlf_pkg::DLF_FR_TURN: begin
					cnt_reg <= 3'h0;
					fr_reg  <= dlf_pkg::DLF_FR_RDAT;
				end
				dlf_pkg::DLF_FR_RDAT: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == dlf_pkg::DLF_LAST_BIT) begin
						fr_reg <= dlf_pkg::DLF_FR_IDLE;
					end
				end
				default: begin
					fr_reg <= dlf_pkg::DLF_FR_IDLE;
				end
			endcase
		end
	end

	// data line drive; only a live read frame ever enables it
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			d_out_reg <= 1'h1;
			d_oe_reg  <= dlf_pkg::DLF_BIT_RST;
			rsh_reg   <= dlf_pkg::DLF_BYTE_RST;
		end else if (fr_reg == dlf_pkg::DLF_FR_TURN) begin
			rsh_reg   <= rd_val; // snapshot, so a late load cannot tear a byte
			d_out_reg <= rd_val[0];
			d_oe_reg  <= live_reg;
		end else if (fr_reg == dlf_pkg::DLF_FR_RDAT && cnt_reg != dlf_pkg::DLF_LAST_BIT) begin
			d_out_reg <= rsh_reg[3'(cnt_reg + 3'h1)];
		end else begin
			d_out_reg <= 1'h1;
			d_oe_reg  <= dlf_pkg::DLF_BIT_RST;
		end
	end

	assign link.dev_d_out = d_out_reg;
	assign link.dev_d_oe  = d_oe_reg;

	// selector and control register
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sel_reg  <= dlf_pkg::DLF_BYTE_RST;
			ctrl_reg <= dlf_pkg::DLF_BYTE_RST;
		end else begin
			if (wr_done && ins_reg == dlf_pkg::DLF_INS_ADDR_WR) begin
				sel_reg <= byte_now;
			end
			if (ctrl_wr) begin
				ctrl_reg <= byte_now;
			end
		end
	end

	// data register; a host write beats a byte loaded from flash
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			data_reg    <= dlf_pkg::DLF_BYTE_RST;
			rd_seen_reg <= dlf_pkg::DLF_BIT_RST;
		end else begin
			rd_seen_reg <= rd_tgl_lk;
			if (data_wr) begin
				data_reg <= byte_now;
			end else if (rd_load_lk) begin
				data_reg <= rd_hold_reg;
			end
		end
	end

	// unlock sequence; the open state has no exit but reset
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lock_reg <= dlf_pkg::DLF_LK_LOCKED;
		end else begin
			case (lock_reg)
				dlf_pkg::DLF_LK_LOCKED: begin
					if (ctrl_wr && byte_now == dlf_pkg::DLF_UNLOCK_A) begin
						lock_reg <= dlf_pkg::DLF_LK_ARMED;
					end
				end
				dlf_pkg::DLF_LK_ARMED: begin
					if (ctrl_wr && byte_now == dlf_pkg::DLF_UNLOCK_B) begin
						lock_reg <= dlf_pkg::DLF_LK_OPEN;
					end else if (ctrl_wr && byte_now != dlf_pkg::DLF_UNLOCK_A) begin
						lock_reg <= dlf_pkg::DLF_LK_LOCKED;
					end
				end
				dlf_pkg::DLF_LK_OPEN: begin
					lock_reg <= dlf_pkg::DLF_LK_OPEN;
				end
				default: begin
					lock_reg <= dlf_pkg::DLF_LK_LOCKED;
				end
			endcase
		end
	end

	// data writes while unlocked are announced by a toggle
	always_ff @(posedge link.link_clk or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_tgl_reg <= dlf_pkg::DLF_BIT_RST;
		end else if (data_wr && lock_reg == dlf_pkg::DLF_LK_OPEN) begin
			wr_tgl_reg <= ~wr_tgl_reg;
		end
	end

	// system side: halt level and flash read byte toward the link
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			halt_src_reg <= dlf_pkg::DLF_BIT_RST;
			rd_tgl_reg   <= dlf_pkg::DLF_BIT_RST;
			rd_hold_reg  <= dlf_pkg::DLF_BYTE_RST;
		end else begin
			halt_src_reg <= halted_in;
			if (rd_byte_load_in) begin
				rd_hold_reg <= rd_byte_in;
				rd_tgl_reg  <= ~rd_tgl_reg;
			end
		end
	end

	// link clock only runs in frames; the start and instruction
	// edges flush these stages before the halt level is used
	dlf_sync u_halt_sync (.clk_in(link.link_clk), .arst_n_in(arst_n_in), .d_in(halt_src_reg),
		.q_out(halt_lk));

	dlf_sync u_rd_sync (.clk_in(link.link_clk), .arst_n_in(arst_n_in), .d_in(rd_tgl_reg),
		.q_out(rd_tgl_lk));

	// one-hot code: the open bit is a flop and safe to cross
	dlf_sync u_mode_sync (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(lock_reg[2]),
		.q_out(prog_mode_out));

	dlf_sync u_wr_sync (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(wr_tgl_reg),
		.q_out(wr_tgl_sys));

	// byte hand-off; data_reg stays still for a whole frame after the toggle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_seen_reg          <= dlf_pkg::DLF_BIT_RST;
			prog_byte_valid_out  <= dlf_pkg::DLF_BIT_RST;
			prog_byte_out        <= dlf_pkg::DLF_BYTE_RST;
			prog_byte_is_cmd_out <= dlf_pkg::DLF_BIT_RST;
		end else begin
			wr_seen_reg         <= wr_tgl_sys;
			prog_byte_valid_out <= wr_tgl_sys ^ wr_seen_reg;
			if (wr_tgl_sys ^ wr_seen_reg) begin
				prog_byte_out        <= data_reg;
				prog_byte_is_cmd_out <= (data_reg == dlf_pkg::DLF_CMD_BLK_RD)
					|| (data_reg == dlf_pkg::DLF_CMD_BLK_WR)
					|| (data_reg == dlf_pkg::DLF_CMD_PG_ERASE)
					|| (data_reg == dlf_pkg::DLF_CMD_DEV_ERASE);
			end
		end
	end
endmodule : dlf_device
`default_nettype wire

// [rtl/dlf_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dlf_host (
	// link side
	dlf_link_if.host        link,
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// register port
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out
);
	dlf_pkg::dlf_ins_t ins_reg;
	logic [7:0]        tx_reg;
	logic [7:0]        rx_reg;
	logic [7:0]        fbyte_reg;
	logic [2:0]        ph_reg;
	logic [3:0]        slot_reg;
	logic [1:0]        seq_reg;
	logic              busy_reg;
	logic              done_reg;
	logic              clk_reg;
	logic              d_out_reg;
	logic              d_oe_reg;
	logic              d_sync;
	logic              is_rd;
	logic              start_req;
	logic              frame_end;

	assign is_rd     = (ins_reg[0] == ins_reg[1]);
	assign start_req = wr_in && addr_in == dlf_pkg::DLF_HREG_CMD && !busy_reg
		&& wdata_in[2:0] <= dlf_pkg::DLF_OP_UNLOCK;
	assign frame_end = busy_reg && ph_reg == dlf_pkg::DLF_PH_LAST
		&& slot_reg == (is_rd ? dlf_pkg::DLF_SLOT_RD_LAST : dlf_pkg::DLF_SLOT_WR_LAST);

	// frame engine; unlock runs three frames back to back
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_reg  <= dlf_pkg::DLF_BIT_RST;
			ph_reg    <= 3'h0;
			slot_reg  <= 4'h0;
			seq_reg   <= 2'h0;
			ins_reg   <= dlf_pkg::DLF_INS_DATA_RD;
			fbyte_reg <= dlf_pkg::DLF_BYTE_RST;
		end else if (start_req) begin
			busy_reg <= 1'h1;
			ph_reg   <= 3'h0;
			slot_reg <= 4'h0;
			if (wdata_in[2:0] == dlf_pkg::DLF_OP_UNLOCK) begin
				ins_reg   <= dlf_pkg::DLF_INS_ADDR_WR;
				fbyte_reg <= dlf_pkg::DLF_SEL_CTRL;
				seq_reg   <= dlf_pkg::DLF_UNLOCK_STEPS;
			end else begin
				ins_reg   <= dlf_pkg::dlf_ins_t'(wdata_in[1:0]);
				fbyte_reg <= tx_reg;
				seq_reg   <= 2'h0;
			end
		end else if (busy_reg) begin
			ph_reg <= (ph_reg == dlf_pkg::DLF_PH_LAST) ? 3'h0 : ph_reg + 3'h1;
			if (frame_end) begin
				slot_reg <= 4'h0;
				if (seq_reg != 2'h0) begin
					seq_reg   <= seq_reg - 2'h1;
					ins_reg   <= dlf_pkg::DLF_INS_DATA_WR;
					fbyte_reg <= (seq_reg == dlf_pkg::DLF_UNLOCK_STEPS)
						? dlf_pkg::DLF_UNLOCK_A : dlf_pkg::DLF_UNLOCK_B;
				end else begin
					busy_reg <= 1'h0;
				end
			end else if (ph_reg == dlf_pkg::DLF_PH_LAST) begin
				slot_reg <= slot_reg + 4'h1;
			end
		end
	end

	// clock idles high like a released reset pin; low pulses stay short
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clk_reg   <= 1'h1;
			d_out_reg <= 1'h1;
			d_oe_reg  <= dlf_pkg::DLF_BIT_RST;
		end else begin
			clk_reg <= !(busy_reg && ph_reg < dlf_pkg::DLF_PH_RISE);
			if (!busy_reg) begin
				d_oe_reg <= 1'h0;
			end else if (ph_reg == 3'h0) begin
				if (slot_reg == 4'h0) begin
					d_out_reg <= 1'h0;
					d_oe_reg  <= 1'h1;
				end else if (slot_reg < dlf_pkg::DLF_SLOT_DATA0) begin
					d_out_reg <= ins_reg[slot_reg[1]];
					d_oe_reg  <= 1'h1;
				end else begin
					d_out_reg <= fbyte_reg[3'(slot_reg - dlf_pkg::DLF_SLOT_DATA0)];
					d_oe_reg  <= !is_rd;
				end
			end
		end
	end

	assign link.link_clk   = clk_reg;
	assign link.host_d_out = d_out_reg;
	assign link.host_d_oe  = d_oe_reg;

	dlf_sync u_data_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.d_in      (link.data),
		.q_out     (d_sync)
	);

	// software registers, read data one cycle after the strobe
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_reg    <= dlf_pkg::DLF_BYTE_RST;
			rx_reg    <= dlf_pkg::DLF_BYTE_RST;
			done_reg  <= dlf_pkg::DLF_BIT_RST;
			rdata_out <= dlf_pkg::DLF_BYTE_RST;
		end else begin
			if (wr_in && addr_in == dlf_pkg::DLF_HREG_TX) begin
				tx_reg <= wdata_in;
			end
			// sample just before the rising edge, lsb first
			if (busy_reg && is_rd && ph_reg == dlf_pkg::DLF_PH_SAMP
				&& slot_reg >= dlf_pkg::DLF_SLOT_RX0) begin
				rx_reg <= {d_sync, rx_reg[7:1]};
			end
			// set beats a clear in the same cycle
			if (frame_end && seq_reg == 2'h0) begin
				done_reg <= 1'h1;
			end else if (wr_in && addr_in == dlf_pkg::DLF_HREG_STAT
				&& wdata_in[dlf_pkg::DLF_STAT_DONE]) begin
				done_reg <= 1'h0;
			end
			if (!rd_in) begin
				rdata_out <= dlf_pkg::DLF_BYTE_RST;
			end else begin
				case (addr_in)
					dlf_pkg::DLF_HREG_CMD:  rdata_out <= {6'h00, ins_reg};
					dlf_pkg::DLF_HREG_TX:   rdata_out <= tx_reg;
					dlf_pkg::DLF_HREG_RX:   rdata_out <= rx_reg;
					dlf_pkg::DLF_HREG_STAT: rdata_out <= {6'h00, done_reg, busy_reg};
					default:                rdata_out <= dlf_pkg::DLF_BYTE_RST;
				endcase
			end
		end
	end
endmodule : dlf_host
`default_nettype wire

// [rtl/dlf_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dlf_sync (
	// destination clock and reset
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	// level in, level out
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_reg;

	// two stages; only the second stage is visible outside
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_reg <= dlf_pkg::DLF_BIT_RST;
			q_out    <= dlf_pkg::DLF_BIT_RST;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule : dlf_sync
`default_nettype wire
